// ==== rtl/port_phy_status_cable_diag_regs.sv ====
// Port-1 status, port-2 control aliases and port-2 cable diagnostic register bank.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "phy_regs_cfg.svh"

module port_phy_status_cable_diag_regs #(
   parameter int CT_TIMEOUT_CYC = `CT_TIMEOUT_CYC
) (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic [`ADDR_W-1:0]  reg_addr,
   input  wire logic [15:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [15:0]         reg_rdata,
   output logic                     irq,
   input  wire logic                polarity_reversed,
   input  wire logic                rx_flow_ctrl_active,
   input  wire logic                tx_flow_ctrl_active,
   input  wire logic                speed_100,
   input  wire logic                full_duplex,
   input  wire logic                mdi_state,
   input  wire logic                an_done,
   input  wire logic                link_good,
   input  wire logic [4:0]          partner_abilities,
   output logic                     crossover_algorithm_select,
   output logic                     cable_test_start,
   input  wire logic                cable_test_done,
   input  wire logic [1:0]          cable_test_result,
   input  wire logic                cable_short_near,
   input  wire logic [8:0]          cable_fault_count,
   output logic                     force_link,
   output logic                     power_save_disable,
   output logic                     near_end_loopback,
   output logic      [95:0]         port2_ctrl_words
);

   localparam int CTW = $clog2(CT_TIMEOUT_CYC + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode.

   logic [7:0] bank;
   logic [3:0] off;
   logic       hit_p1, hit_phy1, hit_p2c, hit_p2s, hit_phy2c, hit_phy2s;
   logic       hit_ist, hit_imk;

   // One-hot register selects from bank and offset.
   assign bank      = reg_addr[`ADDR_W-1:`BANK_LSB];
   assign off       = reg_addr[`BANK_LSB-1:0];
   assign hit_p1    = (bank == `BANK_P1_STATUS) && (off == `OFF_P1_STATUS);
   assign hit_phy1  = (bank == `BANK_PHY1) && (off == `OFF_PHY1_CTRL);
   assign hit_p2c   = (bank == `BANK_P2_CTRL) && !off[0] && (off <= `OFF_P2_LAST);
   assign hit_p2s   = (bank == `BANK_P2_SPECIAL) && (off == `OFF_P2_SPECIAL);
   assign hit_phy2c = (bank == `BANK_PHY2) && (off == `OFF_PHY2_CABLE);
   assign hit_phy2s = (bank == `BANK_PHY2) && (off == `OFF_PHY2_SPECIAL);
   assign hit_ist   = (bank == `BANK_P2_SPECIAL) && (off == `OFF_IRQ_STATUS);
   assign hit_imk   = (bank == `BANK_P2_SPECIAL) && (off == `OFF_IRQ_MASK);

   ////////////////////////////////////////////////////////////////////////////
   // Port-1 live status, sampled every cycle.

   logic [13:0] p1_stat_r;
   logic        link_prev_r;

   // Status comes from same-clock switch logic; one flop gives a stable read image.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         p1_stat_r   <= 14'h0000;
         link_prev_r <= 1'b0;
      end else begin
         p1_stat_r[`B_POLARITY]    <= polarity_reversed;
         p1_stat_r[`B_RX_FC]       <= rx_flow_ctrl_active;
         p1_stat_r[`B_TX_FC]       <= tx_flow_ctrl_active;
         p1_stat_r[`B_SPEED]       <= speed_100;
         p1_stat_r[`B_DUPLEX]      <= full_duplex;
         p1_stat_r[8]              <= 1'b0;
         p1_stat_r[`B_MDI]         <= mdi_state;
         p1_stat_r[`B_AN_DONE]     <= an_done;
         p1_stat_r[`B_LINK_GOOD]   <= link_good;
         p1_stat_r[`B_PARTNER_HI:0] <= partner_abilities;
         link_prev_r               <= p1_stat_r[`B_LINK_GOOD];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Crossover scheme select, shared with the port-1 PHY control bank.

   // Either path writes the one flop, so both always read alike.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         crossover_algorithm_select <= `RST_XOVER_SEL;
      end else if (reg_wr && hit_p1) begin
         crossover_algorithm_select <= reg_wdata[`B_XOVER_SEL];
      end else if (reg_wr && hit_phy1) begin
         crossover_algorithm_select <= reg_wdata[`B_PHY1_XOVER];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port-2 control words, stored for the switch logic.

   logic [15:0] p2_ctrl_r [6];

   // Word index is the byte offset halved.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 6; i++) begin
            p2_ctrl_r[i] <= `RST_P2_CTRL;
         end
      end else if (reg_wr && hit_p2c) begin
         p2_ctrl_r[off[3:1]] <= reg_wdata;
      end
   end

   // Flatten the words onto the output bus, word 0 lowest.
   generate
      for (genvar g = 0; g < 6; g++) begin : g_p2
         assign port2_ctrl_words[g*16 +: 16] = p2_ctrl_r[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Port-2 PHY special controls, shared with the port-2 PHY bank.

   logic wr_sp, wr_phy_sp;
   assign wr_sp     = reg_wr && hit_p2s;
   assign wr_phy_sp = reg_wr && hit_phy2s;

   // The later of two writes wins; they never arrive together.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         force_link         <= 1'b0;
         power_save_disable <= `RST_PWR_SAVE_DIS;
         near_end_loopback  <= 1'b0;
      end else if (wr_sp) begin
         force_link         <= reg_wdata[`B_FORCE_LINK];
         power_save_disable <= reg_wdata[`B_PWR_SAVE_DIS];
         near_end_loopback  <= reg_wdata[`B_NEAR_LB];
      end else if (wr_phy_sp) begin
         force_link         <= reg_wdata[`B_PHY2_FORCE];
         power_save_disable <= reg_wdata[`B_PHY2_PWR];
         near_end_loopback  <= reg_wdata[`B_PHY2_LB];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cable diagnostic sequencer.

   phy_regs_pkg::ct_state_t ct_state_r;
   logic            ct_req;
   logic            ct_end;
   logic            ct_tmo;
   logic [CTW-1:0]  ct_cnt_r;
   logic [1:0]      ct_res_r;
   logic            ct_short_r;
   logic [8:0]      ct_count_r;

   // A start request is a one written to the enable bit through either path.
   assign ct_req = (wr_sp && reg_wdata[`B_CT_EN]) || (reg_wr && hit_phy2c && reg_wdata[`B_PHY2_CT_EN]);
   assign ct_tmo = (ct_cnt_r == CTW'(CT_TIMEOUT_CYC - 1));
   assign ct_end = (ct_state_r == phy_regs_pkg::CT_RUN) && (cable_test_done || ct_tmo);

   // Starts while running are ignored; a silent PHY is reported as failed.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ct_state_r <= phy_regs_pkg::CT_IDLE;
      end else begin
         case (ct_state_r)
            phy_regs_pkg::CT_IDLE: begin
               if (ct_req) begin
                  ct_state_r <= phy_regs_pkg::CT_RUN;
               end
            end
            phy_regs_pkg::CT_RUN: begin
               if (ct_end) begin
                  ct_state_r <= phy_regs_pkg::CT_IDLE;
               end
            end
            default: ct_state_r <= phy_regs_pkg::CT_IDLE;
         endcase
      end
   end

   // Watchdog counter, running only during a test.
   always_ff @(posedge clk) begin
      if (sys_rst || ct_state_r != phy_regs_pkg::CT_RUN) begin
         ct_cnt_r <= '0;
      end else begin
         ct_cnt_r <= ct_cnt_r + CTW'(1);
      end
   end

   // One-cycle start pulse toward the PHY.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cable_test_start <= 1'b0;
      end else begin
         cable_test_start <= (ct_state_r == phy_regs_pkg::CT_IDLE) && ct_req;
      end
   end

   // Results latch at test end so they hold still until the next test.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ct_res_r   <= phy_regs_pkg::CT_NORMAL;
         ct_short_r <= 1'b0;
         ct_count_r <= 9'h000;
      end else if (ct_end) begin
         ct_res_r   <= cable_test_done ? cable_test_result : phy_regs_pkg::CT_FAILED;
         ct_short_r <= cable_test_done && cable_short_near;
         ct_count_r <= cable_test_done ? cable_fault_count : 9'h000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask.

   logic [`IRQ_W-1:0] ist_r;
   logic [`IRQ_W-1:0] imk_r;
   logic [`IRQ_W-1:0] ev;
   logic [`IRQ_W-1:0] ist_nxt;

   assign ev[`IRQ_CT_DONE]  = ct_end;
   assign ev[`IRQ_LINK_CHG] = p1_stat_r[`B_LINK_GOOD] ^ link_prev_r;
   // A new event beats a write-one-to-clear in the same cycle.
   assign ist_nxt = (ist_r & ~((reg_wr && hit_ist) ? reg_wdata[`IRQ_W-1:0] : '0)) | ev;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ist_r <= '0;
      end else begin
         ist_r <= ist_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         imk_r <= `RST_IRQ_MASK;
      end else if (reg_wr && hit_imk) begin
         imk_r <= reg_wdata[`IRQ_W-1:0];
      end
   end

   // Output is registered from the next status value, so it changes on the same edge as the status bit.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ist_nxt & imk_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path.

   logic [15:0] rd_nxt;
   logic        ct_busy;
   assign ct_busy = (ct_state_r == phy_regs_pkg::CT_RUN);

   // Unmapped addresses read zero; reserved bits are never set.
   always_comb begin
      rd_nxt = 16'h0000;
      if (hit_p1) begin
         rd_nxt                = {2'h0, p1_stat_r};
         rd_nxt[`B_XOVER_SEL]  = crossover_algorithm_select;
      end else if (hit_phy1) begin
         rd_nxt[`B_PHY1_XOVER] = crossover_algorithm_select;
      end else if (hit_p2c) begin
         rd_nxt = p2_ctrl_r[off[3:1]];
      end else if (hit_p2s) begin
         rd_nxt = {ct_short_r, ct_res_r, ct_busy, force_link, power_save_disable,
                   near_end_loopback, ct_count_r};
      end else if (hit_phy2c) begin
         rd_nxt[`B_PHY2_CT_EN]    = ct_busy;
         rd_nxt[`B_CT_RES_HI:`B_CT_RES_LO] = ct_res_r;
         rd_nxt[`B_PHY2_CT_SHORT] = ct_short_r;
         rd_nxt[`B_CT_COUNT_HI:0] = ct_count_r;
      end else if (hit_phy2s) begin
         rd_nxt[`B_PHY2_FORCE] = force_link;
         rd_nxt[`B_PHY2_PWR]   = power_save_disable;
         rd_nxt[`B_PHY2_LB]    = near_end_loopback;
      end else if (hit_ist) begin
         rd_nxt[`IRQ_W-1:0] = ist_r;
      end else if (hit_imk) begin
         rd_nxt[`IRQ_W-1:0] = imk_r;
      end
   end

   // Data stand only in the cycle after the read strobe.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= reg_rd ? rd_nxt : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence s_ct_launch;
      (ct_state_r == phy_regs_pkg::CT_IDLE) && ct_req && !sys_rst;
   endsequence

   sequence s_ct_running;
      cable_test_start && ct_busy;
   endsequence

   AST_XOVER_RESET: assert property (@(posedge clk) sys_rst |=> crossover_algorithm_select);
   else $error("crossover select not one after reset");

   AST_XOVER_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && hit_p1 |=> crossover_algorithm_select == $past(reg_wdata[`B_XOVER_SEL]))
   else $error("crossover select write lost");

   AST_P1_READ: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && hit_p1 ##1 !$past(sys_rst)
      |-> reg_rdata[13:9] == $past(p1_stat_r[13:9]) && reg_rdata[7:0] == $past(p1_stat_r[7:0]))
   else $error("port-1 status read mismatch");

   AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && hit_p1 |=> !reg_rdata[14] && !reg_rdata[8])
   else $error("reserved status bit read as one");

   AST_CT_START: assert property (@(posedge clk) disable iff (sys_rst)
      s_ct_launch |=> s_ct_running ##1 !cable_test_start)
   else $error("cable test start pulse wrong");

   AST_CT_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
      ct_busy && cable_test_done |=> !ct_busy ##0 ct_res_r == $past(cable_test_result))
   else $error("cable test not cleared with result");

   AST_CT_TIMEOUT: assert property (@(posedge clk) disable iff (sys_rst)
      ct_busy && ct_tmo && !cable_test_done |=> ct_res_r == phy_regs_pkg::CT_FAILED && !ct_busy)
   else $error("watchdog did not report failure");

   AST_FORCE_ALIAS: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && hit_phy2s |=> reg_rdata[`B_PHY2_FORCE] == force_link
      && reg_rdata[`B_PHY2_LB] == near_end_loopback)
   else $error("PHY alias read differs");

   AST_SPECIAL_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      wr_sp |=> force_link == $past(reg_wdata[11]) && power_save_disable == $past(reg_wdata[10]))
   else $error("special control write lost");

   AST_P2_WORD: assert property (@(posedge clk) disable iff (sys_rst)
      reg_wr && hit_p2c ##1 reg_rd && $past(reg_addr) == reg_addr |=> reg_rdata == $past(reg_wdata, 2))
   else $error("port-2 control word not stored");

   AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 irq == |($past(ist_nxt) & $past(imk_r)))
   else $error("interrupt level wrong");

endmodule // port_phy_status_cable_diag_regs

// ==== rtl/phy_regs_cfg.svh ====
// Address map, field positions, reset values and timing counts of the port status register bank.
`ifndef PHY_REGS_CFG_SVH
`define PHY_REGS_CFG_SVH

// Address layout: bank number above, byte offset in the low nibble.
`define ADDR_W            12
`define BANK_LSB          4
`define BANK_PHY1         8'h2D
`define BANK_PHY2         8'h2F
`define BANK_P1_STATUS    8'h31
`define BANK_P2_CTRL      8'h32
`define BANK_P2_SPECIAL   8'h33
`define OFF_P1_STATUS     4'h4
`define OFF_PHY1_CTRL     4'h0
`define OFF_PHY2_CABLE    4'h4
`define OFF_PHY2_SPECIAL  4'h6
`define OFF_P2_SPECIAL    4'h0
`define OFF_P2_LAST       4'hA
`define OFF_IRQ_STATUS    4'hC
`define OFF_IRQ_MASK      4'hE

// Port-1 status word fields.
`define B_XOVER_SEL       15
`define B_POLARITY        13
`define B_RX_FC           12
`define B_TX_FC           11
`define B_SPEED           10
`define B_DUPLEX          9
`define B_MDI             7
`define B_AN_DONE         6
`define B_LINK_GOOD       5
`define B_PARTNER_HI      4

// Port-2 special word fields.
`define B_CT_SHORT        15
`define B_CT_RES_HI       14
`define B_CT_RES_LO       13
`define B_CT_EN           12
`define B_FORCE_LINK      11
`define B_PWR_SAVE_DIS    10
`define B_NEAR_LB         9
`define B_CT_COUNT_HI     8

// Same bits as they sit in the PHY banks.
`define B_PHY1_XOVER      5
`define B_PHY2_CT_EN      15
`define B_PHY2_CT_SHORT   12
`define B_PHY2_FORCE      3
`define B_PHY2_PWR        2
`define B_PHY2_LB         1

// Interrupt status bits.
`define IRQ_W             2
`define IRQ_CT_DONE       0
`define IRQ_LINK_CHG      1

// Reset values.
`define RST_XOVER_SEL     1'b1
`define RST_PWR_SAVE_DIS  1'b1
`define RST_P2_CTRL       16'h0000
`define RST_IRQ_MASK      2'h0

// Cable test watchdog: time in microseconds and derived cycle count at 100 MHz.
`define CLK_MHZ           100
`define CT_TIMEOUT_US     10000
`define CT_TIMEOUT_CYC    (`CT_TIMEOUT_US * `CLK_MHZ)

`endif

// ==== rtl/phy_regs_pkg.sv ====
// Types shared by the port status and cable diagnostic register bank.
package phy_regs_pkg;

   // Cable diagnostic outcome codes.
   typedef enum logic [1:0] {
      CT_NORMAL = 2'h0,
      CT_OPEN   = 2'h1,
      CT_SHORT  = 2'h2,
      CT_FAILED = 2'h3
   } ct_result_t;

   // Cable diagnostic sequencer states.
   typedef enum logic {
      CT_IDLE,
      CT_RUN
   } ct_state_t;

endpackage

// ==== tb/port_phy_status_cable_diag_regs_bench.sv ====
// Self-checking bench for the port status, port-2 control and cable diagnostic register bank.
`timescale 1ns/1ps
`include "phy_regs_cfg.svh"

module port_phy_status_cable_diag_regs_bench;
   // Short watchdog so the cable test time-out is reached in a few dozen cycles.
   localparam int WD_CYC = 50;

   logic                clk;
   logic                sys_rst;
   logic [`ADDR_W-1:0]  reg_addr;
   logic [15:0]         reg_wdata;
   logic                reg_wr;
   logic                reg_rd;
   logic [15:0]         reg_rdata;
   logic                irq;
   logic [12:0]         st_in;
   logic                xsel;
   logic                ct_start;
   logic                ct_done;
   logic [1:0]          ct_res;
   logic                ct_short;
   logic [8:0]          ct_count;
   logic                force_link;
   logic                pwr_dis;
   logic                loopback;
   logic [95:0]         words;
   logic [15:0]         d;
   int                  err_total;
   int                  n_checks;

   port_phy_status_cable_diag_regs #(.CT_TIMEOUT_CYC(WD_CYC)) i_dut (
      .clk                        (clk),
      .sys_rst                    (sys_rst),
      .reg_addr                   (reg_addr),
      .reg_wdata                  (reg_wdata),
      .reg_wr                     (reg_wr),
      .reg_rd                     (reg_rd),
      .reg_rdata                  (reg_rdata),
      .irq                        (irq),
      .polarity_reversed          (st_in[12]),
      .rx_flow_ctrl_active        (st_in[11]),
      .tx_flow_ctrl_active        (st_in[10]),
      .speed_100                  (st_in[9]),
      .full_duplex                (st_in[8]),
      .mdi_state                  (st_in[7]),
      .an_done                    (st_in[6]),
      .link_good                  (st_in[5]),
      .partner_abilities          (st_in[4:0]),
      .crossover_algorithm_select (xsel),
      .cable_test_start           (ct_start),
      .cable_test_done            (ct_done),
      .cable_test_result          (ct_res),
      .cable_short_near           (ct_short),
      .cable_fault_count          (ct_count),
      .force_link                 (force_link),
      .power_save_disable         (pwr_dis),
      .near_end_loopback          (loopback),
      .port2_ctrl_words           (words)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Clock, reset and the hang guard; the guard is far above the few hundred cycles needed.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Shared bus and compare tasks; every strobe lasts exactly one cycle.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rd_reg(input logic [11:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
      rd_reg(a);
      check(d, exp);
   endtask

   // Write, then read the same word with no idle cycle between the two strobes.
   task automatic wr_rd_chk(input logic [11:0] a, input logic [15:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b1;
      @(posedge clk);
      reg_rd    <= 1'b0;
      #1;
      check(reg_rdata, v);
   endtask

   task automatic end_of_test();
      if (err_total == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Scenarios.
   task automatic t_reset();
      rd_chk(12'h314, 16'h8000);
      check({15'h0, xsel}, 16'h0001);
      rd_chk(12'h330, 16'h0400);
      check({15'h0, pwr_dis}, 16'h0001);
      check({15'h0, irq}, 16'h0000);
   endtask

   // Walks a single one across every status input; status trails its inputs by one cycle.
   task automatic t_status();
      for (int i = 0; i < 13; i++) begin
         @(posedge clk);
         st_in <= 13'h0001 << i;
         repeat (2) @(posedge clk);
         rd_chk(12'h314, {1'b1, 1'b0, st_in[12:8], 1'b0, st_in[7:0]});
      end
      @(posedge clk);
      st_in <= 13'h1FFF;
      wr_reg(12'h314, 16'h7FFF);
      rd_chk(12'h314, 16'h3EFF);
      check({15'h0, xsel}, 16'h0000);
      rd_reg(12'h2D0);
      check({15'h0, d[5]}, 16'h0000);
      wr_reg(12'h2D0, 16'h0020);
      rd_chk(12'h314, 16'hBEFF);
   endtask

   // The link changes above left a pending event; mask it in, then clear it.
   task automatic t_irq_link();
      rd_chk(12'h33C, 16'h0002);
      check({15'h0, irq}, 16'h0000);
      wr_reg(12'h33E, 16'h0002);
      repeat (2) @(posedge clk);
      #1;
      check({15'h0, irq}, 16'h0001);
      wr_reg(12'h33C, 16'h0002);
      repeat (2) @(posedge clk);
      #1;
      check({15'h0, irq}, 16'h0000);
      rd_chk(12'h33C, 16'h0000);
   endtask

   // Distinct values in all six words expose swapped or aliased offsets; a gap address stays empty.
   task automatic t_ctrl_words();
      for (int i = 0; i < 6; i++) begin
         wr_reg(12'h320 + 12'(2 * i), 16'(16'h1111 * (i + 1)));
      end
      wr_reg(12'h32C, 16'hFFFF);
      rd_chk(12'h32C, 16'h0000);
      rd_chk(12'h7F0, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         rd_chk(12'h320 + 12'(2 * i), 16'(16'h1111 * (i + 1)));
         check(words[16 * i +: 16], 16'(16'h1111 * (i + 1)));
      end
      wr_rd_chk(12'h326, 16'hA5C3);
      check(words[63:48], 16'hA5C3);
   endtask

   task automatic t_special();
      wr_reg(12'h330, 16'h0E00);
      check({13'h0, force_link, pwr_dis, loopback}, 16'h0007);
      rd_chk(12'h330, 16'h0E00);
      rd_reg(12'h2F6);
      check({13'h0, d[3:1]}, 16'h0007);
      wr_reg(12'h2F6, 16'h0002);
      rd_chk(12'h330, 16'h0200);
      check({13'h0, force_link, pwr_dis, loopback}, 16'h0001);
      wr_reg(12'h330, 16'h0400);
   endtask

   // One test per outcome code; inputs are scrambled after done to prove the results were latched.
   task automatic t_cable();
      logic [1:0] k;
      wr_reg(12'h33E, 16'h0001);
      for (int i = 0; i < 4; i++) begin
         k = 2'(i);
         wr_reg(12'h330, 16'h1400);
         check({15'h0, ct_start}, 16'h0001);
         rd_reg(12'h330);
         check({15'h0, d[12]}, 16'h0001);
         wr_reg(12'h330, 16'h1400);
         check({15'h0, ct_start}, 16'h0000);
         @(posedge clk);
         ct_done  <= 1'b1;
         ct_res   <= k;
         ct_short <= k[0];
         ct_count <= 9'h1A5 ^ {7'h0, k};
         @(posedge clk);
         ct_done  <= 1'b0;
         ct_res   <= ~k;
         ct_short <= ~k[0];
         ct_count <= 9'h000;
         repeat (2) @(posedge clk);
         #1;
         check({15'h0, irq}, 16'h0001);
         rd_chk(12'h330, {k[0], k, 1'b0, 3'b010, 9'h1A5 ^ {7'h0, k}});
         rd_reg(12'h2F4);
         check({14'h0, d[15], d[12]}, {14'h0, 1'b0, k[0]});
         wr_reg(12'h33C, 16'h0001);
         repeat (2) @(posedge clk);
         #1;
         check({15'h0, irq}, 16'h0000);
      end
   endtask

   // Started through the PHY alias; no done arrives, so the time-out must report a failed outcome.
   task automatic t_watchdog();
      wr_reg(12'h2F4, 16'h8000);
      check({15'h0, ct_start}, 16'h0001);
      repeat (WD_CYC + 10) @(posedge clk);
      rd_chk(12'h330, 16'h6400);
      check({15'h0, irq}, 16'h0001);
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Main sequence: every input has a value at time zero, reset is held four cycles.
   initial begin
      err_total = 0;
      n_checks  = 0;
      sys_rst   = 1'b1;
      reg_addr  = 12'h000;
      reg_wdata = 16'h0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      st_in     = 13'h0000;
      ct_done   = 1'b0;
      ct_res    = 2'h0;
      ct_short  = 1'b0;
      ct_count  = 9'h000;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_status();
      t_irq_link();
      t_ctrl_words();
      t_special();
      t_cable();
      t_watchdog();
      end_of_test();
   end

endmodule // port_phy_status_cable_diag_regs_bench
